// [rtl/i2m_pkg.sv]
// Constants, state types and reset values shared by the two-wire register master
package i2m_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS  = 40;                                    // System clock period
	localparam int BIT_RATE_KBPS  = 100;                                   // Standard-mode rate
	localparam int BIT_PERIOD_NS  = 1000000 / BIT_RATE_KBPS;
	// Least bit time, rounded up so the rate never exceeds the limit
	localparam int BIT_CYC        = (BIT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int QTR_CYC        = (BIT_CYC + 3) / 4;
	localparam int QTR_W          = $clog2(QTR_CYC);
	localparam logic [QTR_W-1:0] QTR_LOAD = QTR_W'(QTR_CYC - 1);

	// ****************************************************************
	// Field widths and bit positions
	// ****************************************************************
	localparam int SLAVE_W        = 7;                                     // 7-bit addressing only
	localparam int BYTE_W         = 8;
	localparam int LEN_W          = 8;
	localparam logic [3:0] ACK_BIT   = 4'h8;                               // Ninth clock of a byte
	localparam logic [3:0] LAST_DATA = 4'h7;
	localparam logic [1:0] Q_DATA    = 2'h0;                               // Quarter that sets SDA
	localparam logic [1:0] Q_RISE    = 2'h1;                               // Quarter that releases SCL
	localparam logic [1:0] Q_SAMPLE  = 2'h2;                               // Quarter that samples SDA
	localparam logic [1:0] Q_FALL    = 2'h3;                               // Quarter that pulls SCL
	localparam logic       DIR_WRITE = 1'h0;
	localparam logic       DIR_READ  = 1'h1;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_START = 5'h02,
		ST_BIT   = 5'h04,
		ST_FETCH = 5'h08,
		ST_STOP  = 5'h10
	} i2m_state_t;

	typedef enum logic [4:0] {
		SG_SADDR_W = 5'h01,
		SG_REGADDR = 5'h02,
		SG_WDATA   = 5'h04,
		SG_SADDR_R = 5'h08,
		SG_RDATA   = 5'h10
	} i2m_stage_t;

	typedef struct packed {
		i2m_state_t          state;
		i2m_stage_t          stage;
		logic [1:0]          q;
		logic [QTR_W-1:0]    tmr;
		logic [3:0]          bitn;
		logic [BYTE_W-1:0]   sh;
		logic                ack_in;
		logic                pend_start;
		logic [SLAVE_W-1:0]  slave;
		logic [BYTE_W-1:0]   regad;
		logic                rnw;
		logic                sep;
		logic [LEN_W-1:0]    left;
		logic                pin_lvl;
		logic                scl_oe_n;
		logic                sda_oe_n;
		logic                ready;
		logic                wr_ready;
		logic                rd_valid;
		logic [BYTE_W-1:0]   rd_data;
		logic                done;
		logic                nack_err;
	} i2m_st_t;

	localparam i2m_st_t ST_RESET = '{
		state: ST_IDLE, stage: SG_SADDR_W, q: 2'h0, tmr: '0, bitn: 4'h0, sh: 8'h00,
		ack_in: 1'h0, pend_start: 1'h0, slave: 7'h00, regad: 8'h00, rnw: 1'h0,
		sep: 1'h0, left: 8'h00, pin_lvl: 1'h0, scl_oe_n: 1'h1, sda_oe_n: 1'h1,
		ready: 1'h1, wr_ready: 1'h0, rd_valid: 1'h0, rd_data: 8'h00, done: 1'h0,
		nack_err: 1'h0};

	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
		logic [1:0] s3;
		logic [1:0] filt;
	} i2m_sync_st_t;

	localparam i2m_sync_st_t SYNC_RESET = '{s1: 2'h3, s2: 2'h3, s3: 2'h3, filt: 2'h3};

endpackage

// [rtl/i2m_line_if.sv]
// Filtered bus line levels passed from the pin synchroniser to the master
`timescale 1ns/1ps
interface i2m_line_if;
	logic scl;
	logic sda;
	modport src (output scl, output sda);
	modport dst (input scl, input sda);
endinterface

// [rtl/i2m_pin_sync.sv]
// Three-stage synchroniser and agreement filter for the SCL and SDA inputs
`timescale 1ns/1ps
module i2m_pin_sync (
	// Clock and reset
	input  wire logic  clock,
	input  wire logic  rst,
	// Raw pins
	input  wire logic  scl_in,
	input  wire logic  sda_in,
	// Filtered levels
	i2m_line_if.src    line
);
	import i2m_pkg::*;

	i2m_sync_st_t st_ff;
	i2m_sync_st_t nxt_st;

	// Stage one is read only by stage two; the filter looks at stages two and three
	always_comb begin
		nxt_st    = st_ff;
		nxt_st.s1 = {scl_in, sda_in};
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		for (int i = 0; i < 2; i++) begin
			if (st_ff.s2[i] == st_ff.s3[i]) begin
				nxt_st.filt[i] = st_ff.s3[i];
			end
		end
	end

	// State register; bus idles high so reset to released
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_ff <= SYNC_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign line.scl = st_ff.filt[1];
	assign line.sda = st_ff.filt[0];
endmodule // i2m_pin_sync

// [rtl/i2m_master.sv]
// Standard-mode two-wire master performing sequential register writes and reads
`timescale 1ns/1ps
module i2m_master (
	// Clock and reset
	input  wire logic                    clock,
	input  wire logic                    rst,
	// Command
	input  wire logic                    cmd_go,
	output logic                         cmd_ready,
	input  wire logic                    cmd_rnw,
	input  wire logic                    cmd_sep_stop,
	input  wire logic [i2m_pkg::SLAVE_W-1:0] cmd_slave,
	input  wire logic [i2m_pkg::BYTE_W-1:0]  cmd_reg,
	input  wire logic [i2m_pkg::LEN_W-1:0]   cmd_len_m1,
	// Write data
	input  wire logic [i2m_pkg::BYTE_W-1:0]  wr_data,
	input  wire logic                    wr_valid,
	output logic                         wr_ready,
	// Read data
	output logic [i2m_pkg::BYTE_W-1:0]   rd_data,
	output logic                         rd_valid,
	// Status
	output logic                         done,
	output logic                         nack_err,
	// Bus pins
	input  wire logic                    scl_in,
	output logic                         scl_o,
	output logic                         scl_oe_n,
	input  wire logic                    sda_in,
	output logic                         sda_o,
	output logic                         sda_oe_n
);
	import i2m_pkg::*;

	// ****************************************************************
	// Checks and synchroniser
	// ****************************************************************
	if (QTR_CYC < 4) begin : g_rate_check
		$error("system clock too slow for the bus rate");
	end

	i2m_line_if line ();

	i2m_pin_sync u_sync (
		.clock  (clock),
		.rst    (rst),
		.scl_in (scl_in),
		.sda_in (sda_in),
		.line   (line.src)
	);

	// Every stage except the read data is driven by the master
	function automatic logic f_is_tx(input i2m_stage_t sg);
		return sg != SG_RDATA;
	endfunction

	i2m_st_t st_ff;
	i2m_st_t nxt_st;
	logic    tick;
	logic    stretch;

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	// Quarter timer pauses while a released SCL is still held low by the slave
	assign stretch = st_ff.scl_oe_n && !line.scl && (st_ff.state != ST_IDLE);
	assign tick    = (st_ff.tmr == '0) && !stretch;

	always_comb begin
		nxt_st          = st_ff;
		nxt_st.wr_ready = 1'b0;
		nxt_st.rd_valid = 1'b0;
		nxt_st.done     = 1'b0;
		if (st_ff.state == ST_IDLE) begin
			if (cmd_go) begin
				nxt_st.state      = ST_START;
				nxt_st.stage      = SG_SADDR_W;
				nxt_st.q          = Q_DATA;
				nxt_st.tmr        = QTR_LOAD;
				nxt_st.slave      = cmd_slave;
				nxt_st.regad      = cmd_reg;
				nxt_st.rnw        = cmd_rnw;
				nxt_st.sep        = cmd_sep_stop;
				nxt_st.left       = cmd_len_m1;
				nxt_st.sh         = {cmd_slave, DIR_WRITE};
				nxt_st.ready      = 1'b0;
				nxt_st.nack_err   = 1'b0;
				nxt_st.pend_start = 1'b0;
			end
		end else if (st_ff.state == ST_FETCH) begin
			// Wait for the next write byte with SCL held low
			if (wr_valid && st_ff.wr_ready) begin
				nxt_st.sh    = wr_data;
				nxt_st.state = ST_BIT;
				nxt_st.bitn  = 4'h0;
				nxt_st.q     = Q_DATA;
				nxt_st.tmr   = QTR_LOAD;
			end else begin
				nxt_st.wr_ready = 1'b1;
			end
		end else if (!tick) begin
			if (!stretch) begin
				nxt_st.tmr = st_ff.tmr - 1'b1;
			end
		end else begin
			nxt_st.tmr = QTR_LOAD;
			nxt_st.q   = st_ff.q + 1'b1;
			case (st_ff.state)
				ST_START: begin
					// Release SDA, release SCL, pull SDA with SCL high, pull SCL
					case (st_ff.q)
						Q_DATA:   nxt_st.sda_oe_n = 1'b1;
						Q_RISE:   nxt_st.scl_oe_n = 1'b1;
						Q_SAMPLE: nxt_st.sda_oe_n = 1'b0;
						default: begin
							nxt_st.scl_oe_n = 1'b0;
							nxt_st.state    = ST_BIT;
							nxt_st.bitn     = 4'h0;
						end
					endcase
				end
				ST_BIT: begin
					case (st_ff.q)
						Q_DATA: begin
							// SDA changes only while SCL is low
							if (st_ff.bitn != ACK_BIT) begin
								nxt_st.sda_oe_n = f_is_tx(st_ff.stage) ? st_ff.sh[BYTE_W-1] : 1'b1;
							end else if (f_is_tx(st_ff.stage)) begin
								nxt_st.sda_oe_n = 1'b1;
							end else begin
								nxt_st.sda_oe_n = (st_ff.left == '0);
							end
						end
						Q_RISE:   nxt_st.scl_oe_n = 1'b1;
						Q_SAMPLE: begin
							if (st_ff.bitn == ACK_BIT) begin
								nxt_st.ack_in = line.sda;
							end else begin
								nxt_st.sh = {st_ff.sh[BYTE_W-2:0], line.sda};
								if (!f_is_tx(st_ff.stage) && st_ff.bitn == LAST_DATA) begin
									nxt_st.rd_data  = {st_ff.sh[BYTE_W-2:0], line.sda};
									nxt_st.rd_valid = 1'b1;
								end
							end
						end
						default: begin
							nxt_st.scl_oe_n = 1'b0;
							nxt_st.bitn     = st_ff.bitn + 1'b1;
							if (st_ff.bitn == ACK_BIT) begin
								nxt_st.bitn = 4'h0;
								if (f_is_tx(st_ff.stage) && st_ff.ack_in) begin
									nxt_st.nack_err = 1'b1;
									nxt_st.state    = ST_STOP;
								end else begin
									case (st_ff.stage)
										SG_SADDR_W: begin
											nxt_st.stage = SG_REGADDR;
											nxt_st.sh    = st_ff.regad;
										end
										SG_REGADDR: begin
											if (st_ff.rnw) begin
												// Read phase reuses the slave address
												nxt_st.stage = SG_SADDR_R;
												nxt_st.sh    = {st_ff.slave, DIR_READ};
												nxt_st.state = st_ff.sep ? ST_STOP : ST_START;
												nxt_st.pend_start = st_ff.sep;
											end else begin
												nxt_st.stage = SG_WDATA;
												nxt_st.state = ST_FETCH;
											end
										end
										SG_WDATA: begin
											if (st_ff.left == '0) begin
												nxt_st.state = ST_STOP;
											end else begin
												nxt_st.left  = st_ff.left - 1'b1;
												nxt_st.state = ST_FETCH;
											end
										end
										SG_SADDR_R: nxt_st.stage = SG_RDATA;
										default: begin
											if (st_ff.left == '0) begin
												nxt_st.state = ST_STOP;
											end else begin
												nxt_st.left = st_ff.left - 1'b1;
											end
										end
									endcase
								end
							end
						end
					endcase
				end
				ST_STOP: begin
					// Pull SDA under low SCL, release SCL, release SDA, bus free
					case (st_ff.q)
						Q_DATA:   nxt_st.sda_oe_n = 1'b0;
						Q_RISE:   nxt_st.scl_oe_n = 1'b1;
						Q_SAMPLE: nxt_st.sda_oe_n = 1'b1;
						default: begin
							if (st_ff.pend_start) begin
								nxt_st.pend_start = 1'b0;
								nxt_st.state      = ST_START;
							end else begin
								nxt_st.state = ST_IDLE;
								nxt_st.ready = 1'b1;
								nxt_st.done  = 1'b1;
							end
						end
					endcase
				end
				default: nxt_st = ST_RESET;
			endcase
		end
	end

	// State register
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_ff <= ST_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Open-drain pins only ever drive low
	assign scl_o     = st_ff.pin_lvl;
	assign sda_o     = st_ff.pin_lvl;
	assign scl_oe_n  = st_ff.scl_oe_n;
	assign sda_oe_n  = st_ff.sda_oe_n;
	assign cmd_ready = st_ff.ready;
	assign wr_ready  = st_ff.wr_ready;
	assign rd_data   = st_ff.rd_data;
	assign rd_valid  = st_ff.rd_valid;
	assign done      = st_ff.done;
	assign nack_err  = st_ff.nack_err;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	localparam int LOW_MIN  = 2 * QTR_CYC - 1;
	localparam int STOP_MAX = 300;

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	// Helper: length of each SCL low phase
	logic [QTR_W+1:0] low_cnt_ff;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			low_cnt_ff <= '0;
		end else begin
			low_cnt_ff <= st_ff.scl_oe_n ? '0 : (&low_cnt_ff ? low_cnt_ff : low_cnt_ff + 1'b1); // Saturate on long waits
		end
	end

	wire bit_q1  = st_ff.state == ST_BIT && st_ff.q == Q_RISE;
	wire end_ack = st_ff.state == ST_BIT && st_ff.bitn == ACK_BIT && st_ff.q == Q_FALL && tick;

	a_scl_low_time: assert property ($rose(st_ff.scl_oe_n) && st_ff.state == ST_BIT |-> low_cnt_ff >= LOW_MIN)
		else $error("SCL low phase shorter than a half bit");
	a_idle_released: assert property (st_ff.state == ST_IDLE |-> st_ff.scl_oe_n && st_ff.sda_oe_n)
		else $error("bus not released while idle");
	a_start_edge: assert property (st_ff.state == ST_START && st_ff.q == Q_SAMPLE && tick
		|=> !st_ff.sda_oe_n && st_ff.scl_oe_n)
		else $error("START not formed with SCL high");
	a_addr_msb: assert property (bit_q1 && st_ff.stage == SG_SADDR_W && st_ff.bitn == 4'h0
		|-> st_ff.sda_oe_n == st_ff.slave[SLAVE_W-1])
		else $error("slave address not sent MSB first");
	a_dir_bit: assert property (bit_q1 && st_ff.bitn == LAST_DATA
		&& st_ff.stage inside {SG_SADDR_W, SG_SADDR_R} |-> st_ff.sda_oe_n == (st_ff.stage == SG_SADDR_R))
		else $error("direction bit wrong");
	a_reg_first: assert property (bit_q1 && st_ff.stage == SG_REGADDR && st_ff.bitn == 4'h0
		|-> st_ff.sda_oe_n == st_ff.regad[BYTE_W-1])
		else $error("register address bit wrong");
	a_read_ack: assert property (bit_q1 && st_ff.stage == SG_RDATA && st_ff.bitn == ACK_BIT
		|-> st_ff.sda_oe_n == (st_ff.left == '0))
		else $error("read acknowledge wrong");
	a_nack_abort: assert property (end_ack && f_is_tx(st_ff.stage) && st_ff.ack_in
		|=> st_ff.state == ST_STOP && st_ff.nack_err ##1 !st_ff.ready [*4])
		else $error("missing ack did not abort with STOP");
	a_write_stop: assert property (end_ack && st_ff.stage == SG_WDATA && !st_ff.ack_in && st_ff.left == '0
		|=> st_ff.state == ST_STOP ##[1:STOP_MAX] st_ff.done)
		else $error("write burst not closed by STOP");
	a_read_reopen: assert property (end_ack && st_ff.stage == SG_REGADDR && !st_ff.ack_in && st_ff.rnw
		|=> st_ff.stage == SG_SADDR_R && (st_ff.state == (st_ff.sep ? ST_STOP : ST_START)))
		else $error("read phase not opened correctly");

	c_write_done: cover property (st_ff.done && !st_ff.nack_err && !st_ff.rnw);
	c_read_done: cover property (st_ff.done && !st_ff.nack_err && st_ff.rnw);
	c_nack_seen: cover property (st_ff.done && st_ff.nack_err);
	c_fresh_start: cover property (st_ff.state == ST_STOP && st_ff.pend_start && st_ff.q == Q_FALL && tick);
endmodule // i2m_master

// [test/i2m_slv.sv]
// Behavioural two-wire slave with a byte-addressed register space, used as the bench partner
`timescale 1ns/1ps
module i2m_slv #(
	parameter logic [6:0] ADDR = 7'h2A
) (
	// Bus lines, pulled up on the board
	input  wire logic scl,
	input  wire logic sda,
	// Bench control: hold SCL low after each falling edge
	input  wire logic stretch,
	// Open-drain drives, low pulls the line
	output logic      scl_oe_n,
	output logic      sda_oe_n
);
	logic [7:0] mem [256];
	logic [7:0] ptr;
	logic [7:0] sh;
	logic [7:0] tx;
	logic       act;
	logic       rd;
	logic       mnack;
	int         n;
	int         idx;
	int         starts;
	int         stops;
	int         nacks;

	initial begin
		scl_oe_n = 1'b1;
		sda_oe_n = 1'b1;
		act = 1'b0;
		n = 0;
		starts = 0;
		stops = 0;
		nacks = 0;
	end

	// START and STOP seen on SDA while SCL is high
	always @(negedge sda) if (scl === 1'b1) begin
		starts++;
		act = 1'b1;
		n = 0;
		idx = 0;
		rd = 1'b0;
		mnack = 1'b0;
		sda_oe_n = 1'b1;
	end
	always @(posedge sda) if (scl === 1'b1) begin
		stops++;
		act = 1'b0;
		sda_oe_n = 1'b1;
	end

	// Sample on the rising edge; bit nine of a read byte is the master's answer
	always @(posedge scl) if (act) begin
		if (n < 8) sh = {sh[6:0], sda};
		else if (rd && idx > 0 && sda) begin
			mnack = 1'b1;
			nacks++;
		end
		n++;
	end

	// Change SDA only while SCL is low, so no false START or STOP appears
	always @(negedge scl) if (act) begin
		if (n == 8 && !(rd && idx > 0)) begin
			if (idx == 0) rd = sh[0];
			else if (idx == 1) ptr = sh;
			else begin
				mem[ptr] = sh;
				ptr++;
			end
			// An address that is not ours is ignored until the next START
			if (idx == 0 && sh[7:1] != ADDR) act = 1'b0;
			else sda_oe_n = 1'b0;
		end else if (n == 8) sda_oe_n = 1'b1;
		else if (n == 9) begin
			n = 0;
			idx++;
			if (rd && !mnack) begin
				tx = mem[ptr];
				ptr++;
				sda_oe_n = tx[7];
			end else sda_oe_n = 1'b1;
		end else if (rd && idx > 0) sda_oe_n = tx[7-n];
	end

	// Slow answer: clock stretching, held past the master's own low half bit so the wait is real
	always @(negedge scl) if (stretch && act) begin
		scl_oe_n = 1'b0;
		#8000 scl_oe_n = 1'b1;
	end
endmodule // i2m_slv

// [test/tb.sv]
// Self-checking bench for the two-wire register master against a slave model
`timescale 1ns/1ps
module tb;
	import i2m_pkg::*;
	logic                clock, rst, cmd_go, cmd_ready, cmd_rnw, cmd_sep_stop;
	logic [SLAVE_W-1:0]  cmd_slave;
	logic [BYTE_W-1:0]   cmd_reg, wr_data, rd_data;
	logic [LEN_W-1:0]    cmd_len_m1;
	logic                wr_valid, wr_ready, rd_valid, done, nack_err, stretch;
	logic                scl_o, scl_oe_n, sda_o, sda_oe_n, s_scl_oe_n, s_sda_oe_n;
	wire                 scl, sda;
	int                  mismatches, samples_checked, s0, p0, a0;
	realtime             last_rise, min_per;
	logic [7:0]          wq [$];
	logic [7:0]          rbuf [$];
	localparam logic [6:0] SLV = 7'h2A;

	// Wired-AND lines with pull-ups
	assign scl = (scl_oe_n ? 1'b1 : scl_o) & s_scl_oe_n;
	assign sda = (sda_oe_n ? 1'b1 : sda_o) & s_sda_oe_n;

	i2m_master i2m_master_i (.clock(clock), .rst(rst), .cmd_go(cmd_go), .cmd_ready(cmd_ready),
		.cmd_rnw(cmd_rnw), .cmd_sep_stop(cmd_sep_stop), .cmd_slave(cmd_slave), .cmd_reg(cmd_reg),
		.cmd_len_m1(cmd_len_m1), .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
		.rd_data(rd_data), .rd_valid(rd_valid), .done(done), .nack_err(nack_err), .scl_in(scl),
		.scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
	i2m_slv #(.ADDR(SLV)) i2m_slv_i (.scl(scl), .sda(sda), .stretch(stretch), .scl_oe_n(s_scl_oe_n),
		.sda_oe_n(s_sda_oe_n));

	always #20 clock = ~clock;

	// Shortest SCL period; stretching only lengthens it
	always @(posedge scl) begin
		if (last_rise > 0 && $realtime - last_rise < min_per) min_per = $realtime - last_rise;
		last_rise = $realtime;
	end

	// ****************************************************************
	// Compare and report
	// ****************************************************************
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp, input string what);
		chk8({7'h00, got}, {7'h00, exp}, what);
	endtask
	task automatic chkn(input int got, input int exp, input string what);
		samples_checked++;
		if (got != exp) begin
			mismatches++;
			$display("MISMATCH %0t %s got %0d exp %0d", $time, what, got, exp);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// One command; bytes of wq fed on the write handshake, read bytes kept in rbuf
	task automatic run(input logic rnw, input logic sep, input logic [6:0] sl, input logic [7:0] rg,
		input logic [7:0] lm1);
		int  i;
		int  k;
		bit  fin;
		k = 0;
		fin = 0;
		rbuf.delete();
		s0 = i2m_slv_i.starts;
		p0 = i2m_slv_i.stops;
		a0 = i2m_slv_i.nacks;
		@(posedge clock);
		cmd_go <= 1'b1;
		cmd_rnw <= rnw;
		cmd_sep_stop <= sep;
		cmd_slave <= sl;
		cmd_reg <= rg;
		cmd_len_m1 <= lm1;
		for (i = 0; i < 60000 && !fin; i++) begin
			@(negedge clock);
			fin = (done === 1'b1);
			if (i == 1) chk1(cmd_ready, 1'b0, "ready low while busy");
			if (fin) chk1(cmd_ready, 1'b1, "ready back with done");
			if (rd_valid === 1'b1) rbuf.push_back(rd_data);
			if (wr_ready === 1'b1 && wr_valid) k++;
			@(posedge clock);
			cmd_go <= 1'b0;
			wr_valid <= (k < wq.size());
			if (k < wq.size()) wr_data <= wq[k];
		end
		if (!fin) begin
			mismatches++;
			$display("MISMATCH %0t command never completed", $time);
			results();
		end
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_write();
		wq = {8'hA5, 8'h3C, 8'h81};
		run(DIR_WRITE, 1'b0, SLV, 8'hFE, 8'h02);
		chk8(i2m_slv_i.mem[8'hFE], 8'hA5, "first write byte");
		chk8(i2m_slv_i.mem[8'hFF], 8'h3C, "second write byte");
		chk8(i2m_slv_i.mem[8'h00], 8'h81, "last write byte");
		chk1(nack_err, 1'b0, "error after good write");
		chkn(i2m_slv_i.starts - s0, 1, "write starts");
		chkn(i2m_slv_i.stops - p0, 1, "write stops");
	endtask
	task automatic t_nack();
		wq = {8'h99};
		run(DIR_WRITE, 1'b0, 7'h15, 8'h10, 8'h00);
		chk1(nack_err, 1'b1, "error on absent slave");
		chkn(i2m_slv_i.stops - p0, 1, "stop after refusal");
		chk1(i2m_slv_i.mem[8'h10] === 8'h99, 1'b0, "refused byte stored");
	endtask
	task automatic t_read_sr();
		wq = {};
		stretch <= 1'b1;
		run(DIR_READ, 1'b0, SLV, 8'hFF, 8'h00);
		stretch <= 1'b0;
		chkn(rbuf.size(), 1, "single read count");
		chk8(rbuf[0], 8'h3C, "single read byte");
		chk1(nack_err, 1'b0, "error cleared by new command");
		chkn(i2m_slv_i.starts - s0, 2, "repeated start count");
		chkn(i2m_slv_i.stops - p0, 1, "one stop with repeated start");
		chkn(i2m_slv_i.nacks - a0, 1, "final byte refused");
	endtask
	task automatic t_read_sep();
		i2m_slv_i.mem[8'h40] = 8'h11;
		i2m_slv_i.mem[8'h41] = 8'hE2;
		i2m_slv_i.mem[8'h42] = 8'h7F;
		run(DIR_READ, 1'b1, SLV, 8'h40, 8'h02);
		chkn(rbuf.size(), 3, "burst read count");
		chk8(rbuf[0], 8'h11, "read byte 0");
		chk8(rbuf[1], 8'hE2, "read byte 1");
		chk8(rbuf[2], 8'h7F, "read byte 2");
		chkn(i2m_slv_i.starts - s0, 2, "fresh start count");
		chkn(i2m_slv_i.stops - p0, 2, "stop between phases");
		chkn(i2m_slv_i.nacks - a0, 1, "only last byte refused");
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		clock = 1'b0;
		rst = 1'b1;
		cmd_go = 1'b0;
		cmd_rnw = 1'b0;
		cmd_sep_stop = 1'b0;
		cmd_slave = 7'h00;
		cmd_reg = 8'h00;
		cmd_len_m1 = 8'h00;
		wr_data = 8'h00;
		wr_valid = 1'b0;
		stretch = 1'b0;
		mismatches = 0;
		samples_checked = 0;
		last_rise = 0;
		min_per = 1.0e9;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		t_write();
		t_nack();
		t_read_sr();
		t_read_sep();
		chk1(min_per >= 10000.0, 1'b1, "SCL faster than standard rate");
		results();
	end
endmodule // tb
